// file: bench/axi_host.sv
// Host microcontroller model: AXI4-Lite master with write and read tasks.
// Assumes the bench bounds every wait with its own cycle limit.
`timescale 1ns/10ps
module axi_host (
  input wire logic aclk,
  output logic [5:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [5:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Released payload is inverted so stale values never look valid
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic aw_d;
    logic w_d;
    aw_d = 0;
    w_d = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready && !aw_d) begin
        aw_d = 1;
        s_axi_awvalid <= 0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wready && !w_d) begin
        w_d = 1;
        s_axi_wvalid <= 0;
        s_axi_wdata <= ~d;
      end
    end while (!(aw_d && w_d));
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    s_axi_araddr <= ~a;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 0;
  endtask
endmodule

// file: bench/rx_wake_status_assertions.sv
// Port checker for the receive and wake status register block.
// Assumes it is bound onto rx_wake_status and sees only its ports.
`timescale 1ns/10ps
module rx_wake_chk
  import rx_wake_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [rx_wake_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [rx_wake_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [rx_wake_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [rx_wake_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic [rx_wake_pkg::NUM_TIMERS-1:0] timer_compare_match,
  input wire logic [rx_wake_pkg::NUM_TIMERS-1:0] timer_compare_flags,
  input wire logic source_match_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves are offered together by the host
  wire aw_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  ////////////////////////////////////////////////////////////////////////////////
  AST_RD_STATUS: assert property (ar_fire && s_axi_araddr == RX_WAKE_STATUS_OFF
    |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h000000)
    else $error("status read answer wrong");
  AST_RD_UNMAPPED: assert property (ar_fire && s_axi_araddr == 6'h00
    |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == RDATA_RST)
    else $error("unmapped read answer wrong");
  AST_WR_RESP: assert property (aw_fire |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_WR_UNMAPPED: assert property (aw_fire && s_axi_awaddr == 6'h00
    |-> ##[1:2] s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
  AST_TMR_SET: assert property (timer_compare_match[0] |-> ##[1:2] timer_compare_flags[0])
    else $error("timer flag missed match");
  AST_TMR_CAUSE: assert property ($rose(timer_compare_flags[0])
    |-> $past(timer_compare_match[0]) || $past(timer_compare_match[0], 2))
    else $error("timer flag rose without match");
  AST_SRC_EN: assert property (aw_fire && s_axi_awaddr == SOURCE_MATCH_CONTROL_OFF
    && s_axi_wstrb[0] && s_axi_wdata[0] |-> ##[1:3] source_match_enable)
    else $error("match enable not set");
endmodule
bind rx_wake_status rx_wake_chk chk_u (.*);

// file: bench/tb_top.sv
// Self-checking bench for the receive and wake status register.
// Assumes the host model and the bound port checker.
`timescale 1ns/10ps
module tb_top;
  import rx_wake_pkg::*;
  logic aclk, aresetn, rx_crc_equal, rx_data_request, rx_source_hit;
  logic cca_channel_busy, buffer_burst_mode;
  logic [15:0] pv;
  logic [31:0] lf;
  logic [33:0] expq[$];
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  wire logic [5:0] s_axi_awaddr, s_axi_araddr;
  wire logic [3:0] s_axi_wstrb, timer_compare_flags;
  wire logic [31:0] s_axi_wdata, s_axi_rdata;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  wire logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire logic source_match_enable;
  rx_wake_status dut_u (.*, .rx_warmup_start(pv[0]), .rx_frame_done(pv[1]),
    .cca_done_event(pv[2]), .sequence_end_event(pv[3]), .aes_complete(pv[4]),
    .buffer_underrun(pv[5]), .wake_por(pv[6]), .wake_hibernate(pv[7]),
    .timer_compare_match(pv[11:8]), .timer_compare_clear(pv[15:12]));
  axi_host host_u (.*);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task tally_and_finish;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One-cycle event pulse on the selected source lines
  task pulse(input logic [15:0] m);
    @(posedge aclk);
    pv <= m;
    @(posedge aclk);
    pv <= 16'h0000;
  endtask
  task chk(input logic [7:0] e);
    expq.push_back({RESP_OKAY, 24'h000000, e});
    host_u.rd(RX_WAKE_STATUS_OFF);
  endtask
  initial begin
    aclk = 0;
    forever #20 aclk = ~aclk;
  end
  // Read monitor compares each answer with the oldest note
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end else if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      total_checks++;
      if ({s_axi_rresp, s_axi_rdata} !== expq[0]) begin
        failures++;
        $display("ERROR rd_word exp %h got %h", expq[0], {s_axi_rresp, s_axi_rdata});
      end
      void'(expq.pop_front());
    end
  end
  initial begin
    {aresetn, rx_crc_equal, rx_data_request, rx_source_hit, pv} = '0;
    {cca_channel_busy, buffer_burst_mode} = '0;
    lf = 32'h5026;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    chk(8'h01);
    host_u.wr(RX_WAKE_STATUS_OFF, 32'h000000F8);
    chk(8'h01);
    host_u.wr(RX_WAKE_STATUS_OFF, 32'h00000001);
    chk(8'h00);
    pulse(16'h0400);
    chk(8'h08);
    pulse(16'h4000);
    chk(8'h00);
    pulse(16'h0010);
    chk(8'h04);
    host_u.wr(RX_WAKE_STATUS_OFF, 32'h000000FB);
    chk(8'h04);
    host_u.wr(RX_WAKE_STATUS_OFF, 32'h00000004);
    chk(8'h00);
    pulse(16'h0020);
    chk(8'h00);
    buffer_burst_mode <= 1;
    pulse(16'h0020);
    chk(8'h02);
    host_u.wr(RX_WAKE_STATUS_OFF, 32'h00000002);
    chk(8'h00);
    cca_channel_busy <= 1;
    pulse(16'h0004);
    chk(8'h40);
    pulse(16'h0001);
    chk(8'h00);
    pulse(16'h0008);
    chk(8'h40);
    cca_channel_busy <= 0;
    pulse(16'h0004);
    chk(8'h00);
    // Random frames, alternating the source match enable
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      host_u.wr(SOURCE_MATCH_CONTROL_OFF, {31'h0, i[0]});
      {rx_source_hit, rx_data_request, rx_crc_equal} <= lf[2:0];
      pulse(16'h0002);
      chk({lf[0], 1'b0, lf[1] & lf[2] & i[0], lf[1], 4'h0});
    end
    // A passing frame first, so the warmup has a set match flag to clear
    {rx_source_hit, rx_data_request, rx_crc_equal} <= 3'b011;
    pulse(16'h0002);
    chk(8'h90);
    pulse(16'h0001);
    chk(8'h00);
    pulse(16'h0100);
    chk(8'h08);
    pulse(16'h0040);
    chk(8'h01);
    pulse(16'h0080);
    chk(8'h09);
    host_u.wr(RX_WAKE_STATUS_OFF, 32'h00000001);
    chk(8'h08);
    expq.push_back({RESP_SLVERR, RDATA_RST});
    host_u.rd(6'h00);
    host_u.wr(6'h00, 32'h000000FF);
    chk(8'h08);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    chk(8'h01);
    // Let the monitor take the last answer before the verdict
    repeat (2) @(posedge aclk);
    tally_and_finish();
  end
endmodule

// file: hdl/rx_wake_status.sv
// Receive and wake status register with an AXI4-Lite slave port.
// Assumes all event inputs are single-cycle pulses or levels on aclk.
//
// Summary of operation
// RULE_01: Bit 7 is one when received FCS equals computed CRC, else zero.
// RULE_02: CRC match flag clears at next receiver warmup, holds until then.
// RULE_03: Bit 6 shows channel busy, valid at CCA and sequence end, clears at warmup.
// RULE_04: Bit 5 set only for data request, matching enabled and table hit.
// RULE_05: Bit 4 set whenever received packet was a data request.
// RULE_06: With wake flag set, bit 3 is zero for power-on wake, one hibernate.
// RULE_07: With wake flag clear, bit 3 is one when any timer flag asserts.
// RULE_08: Bit 3 is read-only; wake flag selects its meaning.
// RULE_09: AES done flag sets on completion; write one clears, zero keeps.
// RULE_10: Underrun flag sets on buffer underrun and stays until written one.
// RULE_11: Underrun flag raised only in burst-mode buffer transfers.
// RULE_12: Wake flag sets on any wake, resets to one, write one clears.
// RULE_13: Status register sits at offset one; all bits but bit 0 reset zero.
// RULE_14: Each timer flag asserts when its comparator matches the counter.
// RULE_15: Writes to bits 7 through 3 do not change them.
`timescale 1ns/10ps
module rx_wake_status (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [rx_wake_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [rx_wake_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rx_wake_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [rx_wake_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Receiver side
  input wire logic rx_warmup_start,
  input wire logic rx_frame_done,
  input wire logic rx_crc_equal,
  input wire logic rx_data_request,
  input wire logic rx_source_hit,
  input wire logic cca_done_event,
  input wire logic sequence_end_event,
  input wire logic cca_channel_busy,
  // AES, packet buffer, wake and timers
  input wire logic aes_complete,
  input wire logic buffer_underrun,
  input wire logic buffer_burst_mode,
  input wire logic wake_por,
  input wire logic wake_hibernate,
  input wire logic [rx_wake_pkg::NUM_TIMERS-1:0] timer_compare_match,
  input wire logic [rx_wake_pkg::NUM_TIMERS-1:0] timer_compare_clear,
  output logic [rx_wake_pkg::NUM_TIMERS-1:0] timer_compare_flags,
  output logic source_match_enable
);
  import rx_wake_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus write channel

  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [DATA_W-1:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic awready_r;
  logic wready_r;

  // Address and data are taken in either order; one write at a time
  wire aw_take = s_axi_awvalid && awready_r;
  wire w_take = s_axi_wvalid && wready_r;
  wire wr_fire = aw_held_r && w_held_r;
  wire wr_status = wr_fire && (aw_addr_r[ADDR_W-1:2] == RX_WAKE_STATUS_OFF[ADDR_W-1:2]);
  wire wr_ctrl = wr_fire && (aw_addr_r[ADDR_W-1:2] == SOURCE_MATCH_CONTROL_OFF[ADDR_W-1:2]);
  wire wr_hit = wr_status || wr_ctrl;
  // Only the low byte lane holds the 8-bit registers
  wire wr_lane0 = w_strb_r[0];
  wire [STAT_W-1:0] w1c_bits = (wr_status && wr_lane0) ? w_data_r[STAT_W-1:0] : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 6'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Ready is registered so every output comes from a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
    end else begin
      awready_r <= !aw_held_r && !aw_take && !bvalid_r && !wr_fire;
      wready_r <= !w_held_r && !w_take && !bvalid_r && !wr_fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  logic src_en_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_en_r <= SOURCE_MATCH_ENABLE_RST;
    end else if (wr_ctrl && wr_lane0) begin
      src_en_r <= w_data_r[SOURCE_MATCH_ENABLE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive result flags, all read-only

  logic crc_match_flag_r;
  logic channel_busy_flag_r;
  logic source_match_flag_r;
  logic poll_request_flag_r;
  wire cca_valid = cca_done_event || sequence_end_event;
  wire src_hit_all = rx_data_request && src_en_r && rx_source_hit;

  // Warmup clears; a frame or CCA result in the same cycle wins over it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_match_flag_r <= 1'b0;
      source_match_flag_r <= 1'b0;
      poll_request_flag_r <= 1'b0;
    end else if (rx_frame_done) begin
      crc_match_flag_r <= rx_crc_equal; // RULE_01
      source_match_flag_r <= src_hit_all; // RULE_04
      poll_request_flag_r <= rx_data_request; // RULE_05
    end else if (rx_warmup_start) begin
      crc_match_flag_r <= 1'b0; // RULE_02
      source_match_flag_r <= 1'b0;
      poll_request_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_busy_flag_r <= 1'b0;
    end else if (cca_valid) begin
      channel_busy_flag_r <= cca_channel_busy; // RULE_03
    end else if (rx_warmup_start) begin
      channel_busy_flag_r <= 1'b0; // RULE_03
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event flags

  logic aes_done_flag;
  logic buffer_underrun_flag;
  logic wake_event_flag;
  logic hibernate_wake_kind_r;
  wire underrun_set = buffer_underrun && buffer_burst_mode; // RULE_11
  wire wake_any = wake_por || wake_hibernate;

  w1c_flag #(.RESET_VAL(1'b0)) u_aes (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(aes_complete),
    .clear(w1c_bits[AES_DONE_BIT]), // RULE_09
    .flag(aes_done_flag)
  );

  w1c_flag #(.RESET_VAL(1'b0)) u_underrun (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(underrun_set),
    .clear(w1c_bits[UNDERRUN_BIT]), // RULE_10
    .flag(buffer_underrun_flag)
  );

  w1c_flag #(.RESET_VAL(RX_WAKE_STATUS_RST[WAKE_EVENT_BIT])) u_wake (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(wake_any),
    .clear(w1c_bits[WAKE_EVENT_BIT]), // RULE_12
    .flag(wake_event_flag)
  );

  // Kind of the last wake; reset itself counts as a power-on wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hibernate_wake_kind_r <= 1'b0;
    end else if (wake_any) begin
      hibernate_wake_kind_r <= wake_hibernate && !wake_por; // RULE_06
    end
  end

  // Timer comparator flags, one sticky bit each
  logic [NUM_TIMERS-1:0] tmr_flags;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
      w1c_flag #(.RESET_VAL(1'b0)) u_tmr (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(timer_compare_match[gi]), // RULE_14
        .clear(timer_compare_clear[gi]),
        .flag(tmr_flags[gi])
      );
    end
  endgenerate

  // Dual meaning of bit 3, chosen by the wake flag
  wire timer_or_wake_kind_flag = wake_event_flag ? hibernate_wake_kind_r // RULE_08
                                                 : (|tmr_flags); // RULE_07

  // Bits 7 to 3 are built only from status; only a write of one to bit 0 reaches bit 3, through the wake flag
  wire [STAT_W-1:0] status_word = {crc_match_flag_r, channel_busy_flag_r, // RULE_15
                                   source_match_flag_r, poll_request_flag_r,
                                   timer_or_wake_kind_flag, aes_done_flag,
                                   buffer_underrun_flag, wake_event_flag};

  ////////////////////////////////////////////////////////////////////////////
  // Bus read channel

  logic arready_r;
  logic rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;
  wire ar_take = s_axi_arvalid && arready_r;
  wire rd_status = s_axi_araddr[ADDR_W-1:2] == RX_WAKE_STATUS_OFF[ADDR_W-1:2]; // RULE_13
  wire rd_ctrl = s_axi_araddr[ADDR_W-1:2] == SOURCE_MATCH_CONTROL_OFF[ADDR_W-1:2];
  wire [DATA_W-1:0] rd_word = rd_status ? {24'h000000, status_word}
                            : rd_ctrl ? {31'h0, src_en_r} : RDATA_RST;

  // Read data is sampled when the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= RDATA_RST;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= (rd_status || rd_ctrl) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r) begin
      if (s_axi_rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end else begin
      arready_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_compare_flags <= 4'h0;
      source_match_enable <= SOURCE_MATCH_ENABLE_RST;
    end else begin
      timer_compare_flags <= tmr_flags;
      source_match_enable <= src_en_r;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule

// file: hdl/w1c_flag.sv
// Sticky event flag with write-one-to-clear.
// Assumes set and clear come from logic on aclk.
`timescale 1ns/10ps
module w1c_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic set,
  input wire logic clear,
  output logic flag
);
  // A set in the clearing cycle wins, so no event is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag <= RESET_VAL;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule

// file: inc/rx_wake_pkg.sv
// Package for the receive and wake status register block.
// Assumes an AXI4-Lite slave with 32-bit data and one aligned word per register.
package rx_wake_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int STAT_W = 8;
  // Register indices, and byte offsets as word indices times four
  localparam logic [ADDR_W-1:0] RX_WAKE_STATUS_IDX = 6'h01;
  localparam logic [ADDR_W-1:0] RX_WAKE_STATUS_OFF = 6'h04;
  localparam logic [ADDR_W-1:0] SOURCE_MATCH_CONTROL_IDX = 6'h08;
  localparam logic [ADDR_W-1:0] SOURCE_MATCH_CONTROL_OFF = 6'h20;
  // Field positions in the status register
  localparam int CRC_MATCH_BIT = 7;
  localparam int CHANNEL_BUSY_BIT = 6;
  localparam int SOURCE_MATCH_BIT = 5;
  localparam int POLL_REQUEST_BIT = 4;
  localparam int TIMER_OR_WAKE_BIT = 3;
  localparam int AES_DONE_BIT = 2;
  localparam int UNDERRUN_BIT = 1;
  localparam int WAKE_EVENT_BIT = 0;
  // Field position in the source match control register
  localparam int SOURCE_MATCH_ENABLE_BIT = 0;
  // Reset values
  localparam logic [STAT_W-1:0] RX_WAKE_STATUS_RST = 8'h01;
  localparam logic SOURCE_MATCH_ENABLE_RST = 1'b0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;
  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Number of timer comparators
  localparam int NUM_TIMERS = 4;
endpackage
